// ### hdl/rcs_pkg.sv
// constants and types shared by the row capture sequencer
package rcs_pkg;
	// array geometry
	localparam int unsigned COLS           = 256;
	localparam int unsigned ROWS           = 300;
	localparam int unsigned ROW_W          = 9;
	localparam logic [8:0]  ROW_LAST       = 9'h12b;

	// register indices and byte addresses (index times four)
	localparam logic [7:0]  IDX_DTIME      = 8'h06;
	localparam logic [7:0]  IDX_DCUR       = 8'h07;
	localparam logic [7:0]  IDX_CTRL       = 8'h20;
	localparam logic [7:0]  IDX_STAT       = 8'h21;
	localparam logic [7:0]  ADDR_DTIME     = 8'(IDX_DTIME * 4);
	localparam logic [7:0]  ADDR_DCUR      = 8'(IDX_DCUR * 4);
	localparam logic [7:0]  ADDR_CTRL      = 8'(IDX_CTRL * 4);
	localparam logic [7:0]  ADDR_STAT      = 8'(IDX_STAT * 4);

	// field positions
	localparam int unsigned CTRL_START_BIT = 0;
	localparam int unsigned CTRL_ROW_LSB   = 16;
	localparam int unsigned STAT_BUSY_BIT  = 0;
	localparam int unsigned STAT_RDY_BIT   = 1;
	localparam int unsigned STAT_REJ_BIT   = 2;
	localparam int unsigned STAT_ROW_LSB   = 16;

	// values after reset
	localparam logic [7:0]  DTIME_RST      = 8'h00;
	localparam logic [7:0]  DCUR_RST       = 8'h00;
	localparam logic [8:0]  ROW_RST        = 9'h000;

	// timing
	localparam int unsigned CLK_NS         = 4;
	localparam int unsigned PRECHARGE_NS   = 40;
	localparam int unsigned DIS_UNIT_NS    = 16;
	localparam int unsigned TMR_W          = 11;
	localparam logic [10:0] PRE_CYCLES     = 11'((PRECHARGE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [10:0] DIS_SCALE      = 11'(DIS_UNIT_NS / CLK_NS);
	localparam logic [10:0] TMR_ONE        = 11'h001;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_PRE   = 5'b00010,
		ST_DIS   = 5'b00100,
		ST_HOLD  = 5'b01000,
		ST_READY = 5'b10000
	} rcs_state_t;

	// signals toward the analog array
	typedef struct packed {
		logic [8:0] row_sel;
		logic       row_active;
		logic       precharge;
		logic       discharge;
		logic       strobe_pre;
		logic       strobe_dis;
		logic [7:0] dis_current;
		logic       row_ready;
	} rcs_array_t;
endpackage

// ### hdl/rcs_timer.sv
// loadable down counter used to time the capture phases
`timescale 1ns/1ps
module rcs_timer #(
	parameter int unsigned W = 11
) (
	input  wire logic         mclk_i,
	input  wire logic         nrst_i,
	input  wire logic         ce_i,
	input  wire logic         load_i,
	input  wire logic [W-1:0] value_i,
	output logic              last_o
);
	logic [W-1:0] cnt;

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			cnt <= '0;
		end else if (ce_i) begin
			if (load_i) begin
				cnt <= value_i;
			end else if (cnt != '0) begin
				cnt <= cnt - W'(1);
			end
		end
	end

	// high in the final cycle of a loaded interval
	assign last_o = (cnt == W'(1));
endmodule

// ### hdl/rcs_top.sv
// row capture sequencer: apb registers, phase sequencing and array strobes
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module rcs_top (
	input  wire logic              mclk_i,
	input  wire logic              nrst_i,
	input  wire logic              ce_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [7:0]        paddr_i,
	input  wire logic [31:0]       pwdata_i,
	output logic [31:0]            prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	output rcs_pkg::rcs_array_t    array_o
);
	rcs_pkg::rcs_state_t state;
	rcs_pkg::rcs_state_t next_state;

	logic [7:0]  discharge_time_setting;
	logic [7:0]  discharge_current_setting;
	logic [8:0]  req_row;
	logic [8:0]  row_sel;
	logic [7:0]  cur_latched;
	logic [10:0] dis_len;
	logic [10:0] next_dis_len;
	logic        rejected;
	logic        tmr_last;
	logic        tmr_load;
	logic [10:0] tmr_value;
	logic        setup;
	logic        access;
	logic        wr;
	logic        mapped;
	logic        start_req;
	logic [8:0]  wr_row;
	logic        start_ok;
	logic [31:0] next_rdata;

	// apb decode; the slave answers in the first access cycle unless frozen
	assign setup    = psel_i && !penable_i;
	assign access   = psel_i && penable_i;
	assign pready_o = ce_i;
	assign mapped   = (paddr_i == rcs_pkg::ADDR_DTIME) || (paddr_i == rcs_pkg::ADDR_DCUR) ||
	                  (paddr_i == rcs_pkg::ADDR_CTRL) || (paddr_i == rcs_pkg::ADDR_STAT);
	assign pslverr_o = access && !mapped;
	assign wr       = access && pwrite_i && ce_i && mapped;
	assign wr_row   = pwdata_i[rcs_pkg::CTRL_ROW_LSB +: rcs_pkg::ROW_W];
	assign start_req = wr && (paddr_i == rcs_pkg::ADDR_CTRL) &&
	                   pwdata_i[rcs_pkg::CTRL_START_BIT];
	// busy or out-of-range starts are dropped and flagged
	assign start_ok = start_req && (wr_row <= rcs_pkg::ROW_LAST) &&
	                  (state == rcs_pkg::ST_IDLE || state == rcs_pkg::ST_READY);

	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (paddr_i)
			rcs_pkg::ADDR_DTIME: next_rdata[7:0] = discharge_time_setting;
			rcs_pkg::ADDR_DCUR:  next_rdata[7:0] = discharge_current_setting;
			rcs_pkg::ADDR_CTRL:  next_rdata[rcs_pkg::CTRL_ROW_LSB +: rcs_pkg::ROW_W] = req_row;
			rcs_pkg::ADDR_STAT: begin
				next_rdata[rcs_pkg::STAT_BUSY_BIT] = !(state == rcs_pkg::ST_IDLE ||
				                                      state == rcs_pkg::ST_READY);
				next_rdata[rcs_pkg::STAT_RDY_BIT]  = (state == rcs_pkg::ST_READY);
				next_rdata[rcs_pkg::STAT_REJ_BIT]  = rejected;
				next_rdata[rcs_pkg::STAT_ROW_LSB +: rcs_pkg::ROW_W] = row_sel;
			end
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// read data is captured in the setup cycle so it comes from a flop
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (ce_i && setup) begin
			prdata_o <= next_rdata;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			discharge_time_setting    <= rcs_pkg::DTIME_RST;
			discharge_current_setting <= rcs_pkg::DCUR_RST;
			req_row                   <= rcs_pkg::ROW_RST;
		end else if (wr) begin
			if (paddr_i == rcs_pkg::ADDR_DTIME) begin
				discharge_time_setting <= pwdata_i[7:0];
			end
			if (paddr_i == rcs_pkg::ADDR_DCUR) begin
				discharge_current_setting <= pwdata_i[7:0];
			end
			if (paddr_i == rcs_pkg::ADDR_CTRL) begin
				req_row <= wr_row;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			rejected <= 1'b0;
		end else if (ce_i) begin
			if (start_req && !start_ok) begin
				rejected <= 1'b1;
			end else if (start_ok) begin
				rejected <= 1'b0;
			end
		end
	end

	// zero would never bring the timer to its last cycle, so it is held to one clock
	always_comb begin
		next_dis_len = 11'(discharge_time_setting) * rcs_pkg::DIS_SCALE;
		if (discharge_time_setting == 8'h00) begin
			next_dis_len = rcs_pkg::TMR_ONE;
		end
	end

	// settings are sampled once per capture so mid-row writes wait a row
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			row_sel     <= rcs_pkg::ROW_RST;
			cur_latched <= rcs_pkg::DCUR_RST;
			dis_len     <= rcs_pkg::TMR_ONE;
		end else if (ce_i && start_ok) begin
			row_sel     <= wr_row;
			cur_latched <= discharge_current_setting;
			dis_len     <= next_dis_len;
		end
	end

	always_comb begin
		next_state = state;
		tmr_load   = 1'b0;
		tmr_value  = rcs_pkg::PRE_CYCLES;
		unique case (state)
			rcs_pkg::ST_IDLE, rcs_pkg::ST_READY: begin
				if (start_ok) begin
					next_state = rcs_pkg::ST_PRE;
					tmr_load   = 1'b1;
				end
			end
			rcs_pkg::ST_PRE: begin
				if (tmr_last) begin
					next_state = rcs_pkg::ST_DIS;
					tmr_load   = 1'b1;
					tmr_value  = dis_len;
				end
			end
			rcs_pkg::ST_DIS: begin
				if (tmr_last) begin
					next_state = rcs_pkg::ST_HOLD;
				end
			end
			rcs_pkg::ST_HOLD: next_state = rcs_pkg::ST_READY;
			default: next_state = rcs_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			state <= rcs_pkg::ST_IDLE;
		end else if (ce_i) begin
			state <= next_state;
		end
	end

	rcs_timer #(
		.W       (rcs_pkg::TMR_W)
	) u_timer (
		.mclk_i  (mclk_i),
		.nrst_i  (nrst_i),
		.ce_i    (ce_i),
		.load_i  (tmr_load),
		.value_i (tmr_value),
		.last_o  (tmr_last)
	);

	assign array_o.row_sel     = row_sel;
	assign array_o.row_active  = !(state == rcs_pkg::ST_IDLE || state == rcs_pkg::ST_READY);
	assign array_o.precharge   = (state == rcs_pkg::ST_PRE);
	assign array_o.discharge   = (state == rcs_pkg::ST_DIS) || (state == rcs_pkg::ST_HOLD);
	// the first strobe sits in the last precharge cycle, where plates are settled
	assign array_o.strobe_pre  = (state == rcs_pkg::ST_PRE) && tmr_last;
	assign array_o.strobe_dis  = (state == rcs_pkg::ST_HOLD);
	assign array_o.dis_current = cur_latched;
	assign array_o.row_ready   = (state == rcs_pkg::ST_READY);

	// helper: discharge cycles seen in the current row
	logic [10:0] dis_seen;
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			dis_seen <= 11'h000;
		end else if (ce_i) begin
			if (state == rcs_pkg::ST_PRE) begin
				dis_seen <= 11'h000;
			end else if (state == rcs_pkg::ST_DIS) begin
				dis_seen <= dis_seen + 11'h001;
			end
		end
	end

	AST_ROW_RANGE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		array_o.row_sel <= rcs_pkg::ROW_LAST)
		else $error("row index beyond last row");
	AST_STROBES_APART: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		!(array_o.strobe_pre && array_o.strobe_dis))
		else $error("both strobes active together");
	AST_NO_RESTART: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(array_o.row_active && start_req) |=> $stable(array_o.row_sel) && rejected)
		else $error("capture restarted while busy");
	AST_PRE_STROBE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(array_o.strobe_pre && ce_i) |-> array_o.precharge ##1 array_o.discharge)
		else $error("first strobe outside precharge");
	AST_DIS_LENGTH: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		array_o.strobe_dis |-> (dis_seen == dis_len))
		else $error("discharge time differs from setting");
	AST_CURRENT: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		$rose(array_o.precharge) |-> array_o.dis_current == $past(discharge_current_setting))
		else $error("current not taken from setting");
	AST_READY: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(array_o.strobe_dis && ce_i) |=> array_o.row_ready && !array_o.discharge)
		else $error("row not ready after second strobe");
	AST_EXCLUSIVE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		!(array_o.precharge && array_o.discharge))
		else $error("precharge and discharge overlap");
	AST_PRE_LEN: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		($rose(array_o.precharge) && ce_i) |-> array_o.precharge [*2])
		else $error("precharge too short");
	AST_LATCH: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(array_o.row_active && wr) |=> $stable(dis_len) && $stable(array_o.dis_current))
		else $error("setting changed during capture");
endmodule

// ### verif/rcs_array_model.sv
// behavioural sensing array that times each capture phase it is driven through
`timescale 1ns/1ps
module rcs_array_model (
	input  wire logic                mclk_i,
	input  wire rcs_pkg::rcs_array_t array_i,
	output integer                   pre_len_o,
	output integer                   dis_len_o,
	output integer                   n_spre_o,
	output integer                   n_sdis_o,
	output integer                   n_bad_o
);
	logic pre_q = 1'b0;
	initial n_bad_o = 0;
	always @(posedge mclk_i) begin
		pre_q <= array_i.precharge;
		// a fresh precharge edge opens a new row, so the phase counters restart
		if (array_i.precharge && !pre_q) begin
			pre_len_o <= 1;
			dis_len_o <= 0;
			n_spre_o <= 0;
			n_sdis_o <= 0;
		end else if (array_i.precharge) begin
			pre_len_o <= pre_len_o + 1;
		end
		if (array_i.discharge)
			dis_len_o <= dis_len_o + 1;
		if (array_i.strobe_pre)
			n_spre_o <= n_spre_o + 1;
		if (array_i.strobe_dis)
			n_sdis_o <= n_sdis_o + 1;
		// plates cannot be precharged and drained at once; strobes need their phase
		if ((array_i.precharge && array_i.discharge) || (array_i.strobe_pre && !array_i.precharge)
				|| (array_i.strobe_dis && !array_i.discharge))
			n_bad_o <= n_bad_o + 1;
	end
endmodule

// ### verif/testbench.sv
// self-checking bench for the row capture sequencer
`timescale 1ns/1ps
module testbench;
	logic                mclk_i;
	logic                nrst_i;
	logic                ce;
	logic                psel;
	logic                pen;
	logic                pwr;
	logic                perr;
	logic                perr_q;
	logic                pready;
	logic [7:0]          paddr;
	logic [31:0]         pwdata;
	logic [31:0]         prdata;
	logic [31:0]         rd;
	rcs_pkg::rcs_array_t arr;
	integer              pre_len, dis_len, n_spre, n_sdis, n_bad;
	int                  n_errors = 0;
	int                  n_compared = 0;

	rcs_top DUT (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(perr), .array_o(arr));
	rcs_array_model PM (.mclk_i(mclk_i), .array_i(arr), .pre_len_o(pre_len),
		.dis_len_o(dis_len), .n_spre_o(n_spre), .n_sdis_o(n_sdis), .n_bad_o(n_bad));

	initial begin
		mclk_i = 1'b0;
		forever #2 mclk_i = ~mclk_i;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_sim;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge mclk_i);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_i);
		pen <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge mclk_i);
			if (pready === 1'b1)
				break;
		end
		if (i == 50) begin
			n_errors++;
			end_sim();
		end
		rd = prdata;
		perr_q = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task automatic wait_ready;
		int i;
		for (i = 0; i < 3000; i++) begin
			@(posedge mclk_i);
			#1;
			if (arr.row_ready === 1'b1)
				break;
		end
		if (i == 3000) begin
			n_errors++;
			end_sim();
		end
	endtask

	task automatic start(input logic [8:0] row);
		apb(1'b1, rcs_pkg::ADDR_CTRL, {7'h00, row, 16'h0001});
	endtask

	// discharge time and current registers after reset, and an unmapped word
	task automatic t_regs;
		apb(1'b0, rcs_pkg::ADDR_DTIME, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(1'b0, rcs_pkg::ADDR_DCUR, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk({rd[30:0], perr_q}, 32'h0000_0001);
	endtask

	task automatic capture(input logic [7:0] dt, input logic [7:0] dc, input logic [8:0] row,
			input int dis);
		apb(1'b1, rcs_pkg::ADDR_DTIME, {24'h000000, dt});
		apb(1'b1, rcs_pkg::ADDR_DCUR, {24'h000000, dc});
		start(row);
		wait_ready();
		chk(pre_len, 32'd10);
		chk(dis_len, dis);
		chk({n_spre[15:0], n_sdis[15:0]}, 32'h0001_0001);
		chk({23'h0, arr.row_sel}, {23'h0, row});
		chk({24'h0, arr.dis_current}, {24'h0, dc});
		chk({31'h0, arr.row_active}, 32'h0000_0000);
		apb(1'b0, rcs_pkg::ADDR_STAT, 32'h0000_0000);
		chk(rd, {7'h00, row, 16'h0002});
	endtask

	// second start and a time rewrite while busy; then an out-of-range row
	task automatic t_overlap;
		apb(1'b1, rcs_pkg::ADDR_DTIME, 32'h0000_0002);
		start(9'h005);
		start(9'h007);
		apb(1'b1, rcs_pkg::ADDR_DTIME, 32'h0000_0030);
		apb(1'b0, rcs_pkg::ADDR_STAT, 32'h0000_0000);
		chk(rd, 32'h0005_0005);
		chk({31'h0, arr.row_active}, 32'h0000_0001);
		wait_ready();
		chk(dis_len, 32'd9);
		chk({23'h0, arr.row_sel}, 32'h0000_0005);
		start(9'h12c);
		apb(1'b0, rcs_pkg::ADDR_STAT, 32'h0000_0000);
		chk(rd, 32'h0005_0006);
	endtask

	// clock enable low in precharge stretches it and holds pready low
	task automatic t_freeze;
		apb(1'b1, rcs_pkg::ADDR_DTIME, 32'h0000_0001);
		start(9'h003);
		@(posedge mclk_i);
		ce <= 1'b0;
		repeat (4) @(posedge mclk_i);
		chk({31'h0, pready}, 32'h0000_0000);
		ce <= 1'b1;
		wait_ready();
		chk(pre_len, 32'd14);
		chk(dis_len, 32'd5);
		chk({n_spre[15:0], n_sdis[15:0]}, 32'h0001_0001);
		chk({31'h0, arr.row_active}, 32'h0000_0000);
	endtask

	initial begin
		nrst_i = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (5) @(posedge mclk_i);
		nrst_i <= 1'b1;
		t_regs();
		capture(8'h01, 8'h5a, 9'h12b, 5);
		capture(8'h00, 8'hff, 9'h000, 2);
		t_overlap();
		capture(8'h03, 8'h81, 9'h0ff, 13);
		t_freeze();
		chk(n_bad, 32'd0);
		end_sim();
	end
endmodule
